/* include/cim_regs.vh */
// Purpose: Constants for the compact instruction execute block.
// Assumes: 16-bit instruction words, 32-bit general registers.
// Notes:   Definitions only.
`ifndef CIM_REGS_VH
`define CIM_REGS_VH

// ----------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------
`define CIM_MAJ_I8        5'h0C
`define CIM_MAJ_RR        5'h1D
`define CIM_I8_COPY_TO32  3'h5
`define CIM_I8_COPY_FR32  3'h7
`define CIM_I8_FRAME      3'h4
`define CIM_RR_SPROD      5'h18
`define CIM_RR_UPROD      5'h19
`define CIM_RR_NEGATE     5'h0B
`define CIM_RR_COMPL      5'h0F
`define CIM_RR_UNION      5'h0D
`define CIM_IDLE_WORD     16'h6500
`define CIM_FR_SAVE_BIT   7
`define CIM_FR_RA_BIT     6
`define CIM_FR_S0_BIT     5
`define CIM_FR_S1_BIT     4

// ----------------------------------------------------------------
// Register numbers and frame arithmetic
// ----------------------------------------------------------------
`define CIM_GPR_ZERO      5'h00
`define CIM_GPR_S0        5'h10
`define CIM_GPR_S1        5'h11
`define CIM_GPR_SP        5'h1D
`define CIM_GPR_RA        5'h1F
`define CIM_FRAME_ZERO    32'h0000_0080
`define CIM_WORD_STEP     32'h0000_0004
`define CIM_SHORT_LIMIT   3'h2

// ----------------------------------------------------------------
// Load response and exception codes
// ----------------------------------------------------------------
`define CIM_LDE_OK        2'h0
`define CIM_EXC_NONE      3'h0
`define CIM_EXC_ADDR      3'h1
`define CIM_EXC_REFILL    3'h2
`define CIM_EXC_INVALID   3'h3
`define CIM_EXC_BUS       3'h4

// ----------------------------------------------------------------
// Register map and status bits
// ----------------------------------------------------------------
`define CIM_REG_STATUS    8'h00
`define CIM_REG_CLEAR     8'h04
`define CIM_REG_ENABLE    8'h08
`define CIM_REG_STATE     8'h0C
`define CIM_REG_PROD_HI   8'h10
`define CIM_REG_PROD_LO   8'h14
`define CIM_STS_ADDR_ERR  0
`define CIM_STS_LOAD_EXC  1
`define CIM_STS_MUL_DONE  2
`define CIM_STS_FR_DONE   3
`define CIM_STS_W         4
`define CIM_MUL_LAT       8'h03

`endif

/* rtl/cim_core.v */
// Purpose: Decode and execute of register copies, multiplies, negate, complement,
//          inclusive union and the basic frame unwind reload.
// Assumes: One clock; fetch and the load path share it; load path translates addresses.
// Notes:   Product registers are written in the background after MUL_LAT cycles.
//
// What this block does
// - Word 6500h copies register 16 into hard-wired register 0, changing nothing.
// - Major 01100 copy forms move the 3-bit register into the 5-bit target (sub 5) and the 5-bit register into the 3-bit target (sub 7).
// - The 5-bit register field addresses all 32 registers without short mapping.
// - Signed multiply puts product low word in bottom half, high word in upper.
// - Unsigned multiply splits its 64-bit product the same way.
// - Multiplies never raise an arithmetic or overflow exception.
// - A product read on prod_rd_req before the result is written stalls until ready; bus reads do not stall.
// - Negate writes zero minus the y operand into the x register.
// - Complement writes the inverted y operand into the x register.
// - Inclusive union ORs x and y and writes back into x.
// - Unwind adds eight times frame units to the stack pointer; zero means 128.
// - Reload 31, then 17, then 16, stepping down four bytes from new pointer.
// - The adjusted stack pointer is written to register 29 after the reloads.
// - Misaligned stack pointer with any reload bit set gives an address error.
// - Reload words use the translated load path; its faults are reported.
// - An interrupted unwind restarts whole; it takes a variable cycle count.
`include "cim_regs.vh"

module cim_core #(
    parameter [7:0] MUL_LAT = `CIM_MUL_LAT
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        instr_valid,
    input  wire [15:0] instr,
    output reg         instr_ready_q,
    input  wire        prod_rd_req,
    input  wire        prod_rd_upper,
    output reg         prod_rd_valid_q,
    output reg  [31:0] prod_rd_data_q,
    output reg         mem_req_q,
    output reg  [31:0] mem_addr_q,
    input  wire        mem_rsp_valid,
    input  wire [31:0] mem_rsp_data,
    input  wire [1:0]  mem_rsp_err,
    output reg         exc_valid_q,
    output reg  [2:0]  exc_code_q,
    output reg  [31:0] exc_addr_q,
    input  wire [4:0]  gpr_rd_idx,
    output reg  [31:0] gpr_rd_data_q,
    input  wire [7:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [31:0] bus_rdata_q,
    output reg         irq_q
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;

    function [4:0] xlat;
        input [2:0] code;
        begin
            if (code < `CIM_SHORT_LIMIT)
                xlat = `CIM_GPR_S0 | {4'h0, code[0]};
            else
                xlat = {2'h0, code};
        end
    endfunction

    reg [31:0] gpr_q [0:31];
    reg [31:0] hi_q;
    reg [31:0] lo_q;
    reg [63:0] pend_q;
    reg [7:0]  mul_cnt_q;
    reg        rd_pend_q;
    reg        rd_upper_q;
    reg [1:0]  st_q;
    reg [2:0]  rs_mask_q;
    reg [31:0] rs_addr_q;
    reg [31:0] rs_sp_q;
    reg [4:0]  rs_dst_q;
    reg [3:0]  sts_q;
    reg [3:0]  en_q;
    integer    i;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire        take   = instr_valid & instr_ready_q;
    wire [4:0]  major  = instr[15:11];
    wire [2:0]  sub8   = instr[10:8];
    wire [4:0]  func   = instr[4:0];
    wire [4:0]  rx_idx = xlat(instr[10:8]);
    wire [4:0]  ry_idx = xlat(instr[7:5]);
    wire [4:0]  rz_idx = xlat(instr[2:0]);
    wire [4:0]  w32_a  = {instr[4:3], instr[7:5]};
    wire [4:0]  w32_b  = instr[4:0];
    wire [31:0] opx    = gpr_q[rx_idx];
    wire [31:0] opy    = gpr_q[ry_idx];
    wire        is_i8  = (major == `CIM_MAJ_I8);
    wire        is_rr  = (major == `CIM_MAJ_RR);
    wire        is_fr  = is_i8 && (sub8 == `CIM_I8_FRAME) && !instr[`CIM_FR_SAVE_BIT];
    wire        do_sp  = take && is_rr && (func == `CIM_RR_SPROD);
    wire        do_up  = take && is_rr && (func == `CIM_RR_UPROD);
    wire        mul_go = do_sp | do_up;
    wire [2:0]  fr_bits = {instr[`CIM_FR_RA_BIT], instr[`CIM_FR_S1_BIT], instr[`CIM_FR_S0_BIT]};
    wire [31:0] fr_add = (instr[3:0] == 4'h0) ? `CIM_FRAME_ZERO : {25'h0, instr[3:0], 3'h0};
    wire [31:0] fr_sp  = gpr_q[`CIM_GPR_SP] + fr_add;
    wire        fr_mis = (fr_sp[1:0] != 2'h0) && (fr_bits != 3'h0);

    // Signed operands are sign-extended to 64 bits; the low 64 bits of the
    // product are then right for both kinds, and no overflow is ever flagged.
    wire [63:0] ext_x  = {{32{do_sp & opx[31]}}, opx};
    wire [63:0] ext_y  = {{32{do_sp & opy[31]}}, opy};
    wire [63:0] prod   = ext_x * ext_y;
    wire        busy   = (mul_cnt_q != 8'h00);

    // Single-register result of the current instruction.
    reg        wr_en;
    reg [4:0]  wr_idx;
    reg [31:0] wr_val;
    always @*
    begin
        wr_en  = 1'b0;
        wr_idx = `CIM_GPR_ZERO;
        wr_val = 32'h0000_0000;
        if (take && is_i8 && sub8 == `CIM_I8_COPY_TO32)
        begin
            wr_en  = 1'b1;
            wr_idx = w32_a;
            wr_val = gpr_q[rz_idx];
        end
        else if (take && is_i8 && sub8 == `CIM_I8_COPY_FR32)
        begin
            wr_en  = 1'b1;
            wr_idx = ry_idx;
            wr_val = gpr_q[w32_b];
        end
        else if (take && is_rr && func == `CIM_RR_NEGATE)
        begin
            wr_en  = 1'b1;
            wr_idx = rx_idx;
            wr_val = 32'h0000_0000 - opy;
        end
        else if (take && is_rr && func == `CIM_RR_COMPL)
        begin
            wr_en  = 1'b1;
            wr_idx = rx_idx;
            wr_val = ~opy;
        end
        else if (take && is_rr && func == `CIM_RR_UNION)
        begin
            wr_en  = 1'b1;
            wr_idx = rx_idx;
            wr_val = opx | opy;
        end
    end

    // ----------------------------------------------------------------
    // Unwind sequencer and register file
    // ----------------------------------------------------------------
    wire [4:0] next_dst = rs_mask_q[2] ? `CIM_GPR_RA : (rs_mask_q[1] ? `CIM_GPR_S1 : `CIM_GPR_S0);
    wire [2:0] next_mask = rs_mask_q[2] ? {1'b0, rs_mask_q[1:0]}
                         : (rs_mask_q[1] ? {2'h0, rs_mask_q[0]} : 3'h0);
    wire [31:0] step_addr = rs_addr_q - `CIM_WORD_STEP;
    wire        ld_err = mem_rsp_valid && (mem_rsp_err != `CIM_LDE_OK);

    reg [3:0] ev;
    always @*
    begin
        ev = 4'h0;
        ev[`CIM_STS_ADDR_ERR] = take && is_fr && fr_mis;
        ev[`CIM_STS_LOAD_EXC] = (st_q == ST_WAIT) && ld_err;
        ev[`CIM_STS_MUL_DONE] = (mul_cnt_q == 8'h01);
        ev[`CIM_STS_FR_DONE]  = (st_q == ST_ISSUE) && (rs_mask_q == 3'h0);
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (i = 0; i < 32; i = i + 1)
                gpr_q[i] <= 32'h0000_0000;
            st_q          <= ST_IDLE;
            rs_mask_q     <= 3'h0;
            rs_addr_q     <= 32'h0000_0000;
            rs_sp_q       <= 32'h0000_0000;
            rs_dst_q      <= `CIM_GPR_ZERO;
            instr_ready_q <= 1'b0;
            mem_req_q     <= 1'b0;
            mem_addr_q    <= 32'h0000_0000;
            exc_valid_q   <= 1'b0;
            exc_code_q    <= `CIM_EXC_NONE;
            exc_addr_q    <= 32'h0000_0000;
        end
        else
        begin
            mem_req_q   <= 1'b0;
            exc_valid_q <= 1'b0;
            if (wr_en && wr_idx != `CIM_GPR_ZERO)
                gpr_q[wr_idx] <= wr_val;
            case (st_q)
                ST_IDLE:
                begin
                    instr_ready_q <= 1'b1;
                    if (take && is_fr)
                    begin
                        if (fr_mis)
                        begin
                            exc_valid_q <= 1'b1;
                            exc_code_q  <= `CIM_EXC_ADDR;
                            exc_addr_q  <= fr_sp - `CIM_WORD_STEP;
                        end
                        else
                        begin
                            instr_ready_q <= 1'b0;
                            st_q          <= ST_ISSUE;
                            rs_mask_q     <= fr_bits;
                            rs_addr_q     <= fr_sp;
                            rs_sp_q       <= fr_sp;
                        end
                    end
                end
                ST_ISSUE:
                begin
                    if (rs_mask_q == 3'h0)
                    begin
                        gpr_q[`CIM_GPR_SP] <= rs_sp_q;
                        instr_ready_q      <= 1'b1;
                        st_q               <= ST_IDLE;
                    end
                    else
                    begin
                        mem_req_q  <= 1'b1;
                        mem_addr_q <= step_addr;
                        rs_addr_q  <= step_addr;
                        rs_dst_q   <= next_dst;
                        rs_mask_q  <= next_mask;
                        st_q       <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (ld_err)
                    begin
                        // Nothing of the frame is committed to the stack pointer, so
                        // the handler's return re-runs the whole unwind.
                        exc_valid_q   <= 1'b1;
                        exc_code_q    <= `CIM_EXC_ADDR + {1'b0, mem_rsp_err};
                        exc_addr_q    <= rs_addr_q;
                        instr_ready_q <= 1'b1;
                        st_q          <= ST_IDLE;
                    end
                    else if (mem_rsp_valid)
                    begin
                        gpr_q[rs_dst_q] <= mem_rsp_data;
                        st_q            <= ST_ISSUE;
                    end
                end
                default:
                begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Background multiplier and product reads
    // ----------------------------------------------------------------
    wire rd_want  = prod_rd_req | rd_pend_q;
    wire rd_upper = prod_rd_req ? prod_rd_upper : rd_upper_q;
    wire rd_go    = rd_want && !busy && !mul_go;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hi_q            <= 32'h0000_0000;
            lo_q            <= 32'h0000_0000;
            pend_q          <= 64'h0;
            mul_cnt_q       <= 8'h00;
            rd_pend_q       <= 1'b0;
            rd_upper_q      <= 1'b0;
            prod_rd_valid_q <= 1'b0;
            prod_rd_data_q  <= 32'h0000_0000;
        end
        else
        begin
            if (mul_go)
            begin
                pend_q    <= prod;
                mul_cnt_q <= MUL_LAT;
            end
            else if (busy)
            begin
                mul_cnt_q <= mul_cnt_q - 8'h01;
                if (mul_cnt_q == 8'h01)
                begin
                    lo_q <= pend_q[31:0];
                    hi_q <= pend_q[63:32];
                end
            end
            rd_upper_q      <= rd_upper;
            rd_pend_q       <= rd_want && !rd_go;
            prod_rd_valid_q <= rd_go;
            if (rd_go)
                prod_rd_data_q <= rd_upper ? hi_q : lo_q;
        end
    end

    // ----------------------------------------------------------------
    // Register port and interrupt
    // ----------------------------------------------------------------
    wire [3:0] clr = (bus_wr && bus_addr == `CIM_REG_CLEAR) ? bus_wdata[3:0] : 4'h0;
    wire [3:0] sts_d = (sts_q & ~clr) | ev;
    wire [3:0] en_d  = (bus_wr && bus_addr == `CIM_REG_ENABLE) ? bus_wdata[3:0] : en_q;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sts_q         <= 4'h0;
            en_q          <= 4'h0;
            irq_q         <= 1'b0;
            bus_rdata_q   <= 32'h0000_0000;
            gpr_rd_data_q <= 32'h0000_0000;
        end
        else
        begin
            sts_q         <= sts_d;
            en_q          <= en_d;
            irq_q         <= |(sts_d & en_d);
            gpr_rd_data_q <= gpr_q[gpr_rd_idx];
            bus_rdata_q   <= 32'h0000_0000;
            if (bus_rd)
            begin
                if (bus_addr == `CIM_REG_STATUS)
                    bus_rdata_q <= {28'h0, sts_q};
                else if (bus_addr == `CIM_REG_ENABLE)
                    bus_rdata_q <= {28'h0, en_q};
                else if (bus_addr == `CIM_REG_STATE)
                    bus_rdata_q <= {21'h0, busy, rs_mask_q, rs_dst_q, st_q};
                else if (bus_addr == `CIM_REG_PROD_HI)
                    bus_rdata_q <= hi_q;
                else if (bus_addr == `CIM_REG_PROD_LO)
                    bus_rdata_q <= lo_q;
            end
        end
    end

endmodule

/* sim/cim_chk.sv */
// Purpose: Port-level checks on the compact instruction execute block.
// Assumes: One clock; rstn asynchronous and active low.
// Notes:   Bound onto every cim_core instance.
module cim_chk #(
    parameter [7:0] MUL_LAT = 8'h03
) (
    input wire        clk,
    input wire        rstn,
    input wire        instr_valid,
    input wire [15:0] instr,
    input wire        instr_ready_q,
    input wire        prod_rd_req,
    input wire        prod_rd_valid_q,
    input wire        mem_req_q,
    input wire [31:0] mem_addr_q,
    input wire        mem_rsp_valid,
    input wire [1:0]  mem_rsp_err,
    input wire        exc_valid_q,
    input wire [2:0]  exc_code_q,
    input wire [31:0] exc_addr_q,
    input wire [4:0]  gpr_rd_idx,
    input wire [31:0] gpr_rd_data_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire       take   = instr_valid && instr_ready_q;
    wire       is_mul = take && instr[15:11] == 5'h1D && instr[4:1] == 4'hC;
    wire       is_unw = take && instr[15:8] == 8'h64 && !instr[7];
    reg        seen_q;
    reg [31:0] last_q;
    // Remembers the previous reload address of the running unwind.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seen_q <= 1'b0;
            last_q <= 32'h0;
        end
        else if (mem_req_q)
        begin
            seen_q <= 1'b1;
            last_q <= mem_addr_q;
        end
        else if (instr_ready_q)
            seen_q <= 1'b0;
    end
    a_mul_no_early: assert property (MUL_LAT >= 8'h03 && is_mul |=> !prod_rd_valid_q [*3])
        else $error("product answered before multiply finished");
    a_rd_bounded: assert property (prod_rd_req |-> ##[1:8] prod_rd_valid_q)
        else $error("product read never answered");
    a_mul_no_exc: assert property (is_mul |=> !exc_valid_q)
        else $error("multiply raised an exception");
    a_unw_empty: assert property (is_unw && instr[6:4] == 3'h0 |=> !instr_ready_q ##1 instr_ready_q)
        else $error("empty unwind did not finish in two cycles");
    a_load_aligned: assert property (mem_req_q |-> mem_addr_q[1:0] == 2'b00)
        else $error("misaligned reload issued");
    a_load_busy: assert property (mem_req_q |-> !instr_ready_q)
        else $error("reload while accepting instructions");
    a_addr_step: assert property (mem_req_q && seen_q |-> mem_addr_q == last_q - 32'h4)
        else $error("reload address did not step down one word");
    a_mis_exc: assert property (exc_valid_q && exc_code_q == 3'h1 |-> exc_addr_q[1:0] != 2'b00 && $past(is_unw))
        else $error("address error without misaligned unwind");
    a_ld_err: assert property (mem_rsp_valid && mem_rsp_err != 2'b00 |=>
        exc_valid_q && exc_code_q == $past(mem_rsp_err) + 3'h1 && exc_addr_q == $past(mem_addr_q))
        else $error("load fault not reported");
    a_zero_reg: assert property (gpr_rd_idx == 5'h00 |=> gpr_rd_data_q == 32'h0)
        else $error("register zero changed");
endmodule
bind cim_core cim_chk #(.MUL_LAT(MUL_LAT)) u_chk (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr(instr), .instr_ready_q(instr_ready_q), .prod_rd_req(prod_rd_req), .prod_rd_valid_q(prod_rd_valid_q),
    .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_err(mem_rsp_err),
    .exc_valid_q(exc_valid_q), .exc_code_q(exc_code_q), .exc_addr_q(exc_addr_q), .gpr_rd_idx(gpr_rd_idx),
    .gpr_rd_data_q(gpr_rd_data_q));

/* sim/cim_load_model.sv */
// Purpose: Stand-in for address translation and the data load path.
// Assumes: One load outstanding; answer after lat+1 idle cycles.
// Notes:   A word reads as its address ORed with F0000001h; err_sel faults it.
module cim_load_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        mem_req_q,
    input  wire logic [31:0] mem_addr_q,
    input  wire logic [1:0]  err_sel,
    input  wire logic [3:0]  lat,
    output logic             mem_rsp_valid,
    output logic [31:0]      mem_rsp_data,
    output logic [1:0]       mem_rsp_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        busy;
    logic [3:0]  cnt;
    logic [31:0] addr;
    // Outside an answer the data and code lines toggle so stale values never match.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            addr <= 32'h0;
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= 32'h0;
            mem_rsp_err <= 2'h0;
        end
        else
        begin
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= ~mem_rsp_data;
            mem_rsp_err <= ~mem_rsp_err;
            if (mem_req_q)
            begin
                busy <= 1'b1;
                cnt <= lat;
                addr <= mem_addr_q;
            end
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                mem_rsp_valid <= 1'b1;
                mem_rsp_data <= 32'hF000_0001 | addr;
                mem_rsp_err <= err_sel;
            end
        end
    end
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for cim_core; the bench acts as instruction fetch.
// Assumes: cim_load_model answers reloads.
// Notes:   Expected words follow the load model pattern.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [15:0] instr = 16'h0;
    logic        prod_rd_req = 1'b0;
    logic        prod_rd_upper = 1'b0;
    logic [4:0]  gpr_rd_idx = 5'h0;
    logic [7:0]  bus_addr = 8'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [1:0]  err_sel = 2'h0;
    logic [3:0]  lat = 4'h2;
    wire         instr_ready_q, prod_rd_valid_q, mem_req_q, mem_rsp_valid, exc_valid_q, irq_q;
    wire [31:0]  prod_rd_data_q, mem_addr_q, mem_rsp_data, exc_addr_q, gpr_rd_data_q, bus_rdata_q;
    wire [1:0]   mem_rsp_err;
    wire [2:0]   exc_code_q;
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          exc_n = 0;
    cim_core uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr), .instr_ready_q(instr_ready_q),
        .prod_rd_req(prod_rd_req), .prod_rd_upper(prod_rd_upper), .prod_rd_valid_q(prod_rd_valid_q),
        .prod_rd_data_q(prod_rd_data_q), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .mem_rsp_err(mem_rsp_err),
        .exc_valid_q(exc_valid_q), .exc_code_q(exc_code_q), .exc_addr_q(exc_addr_q), .gpr_rd_idx(gpr_rd_idx),
        .gpr_rd_data_q(gpr_rd_data_q), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .irq_q(irq_q));
    cim_load_model u_mem (.clk(clk), .rstn(rstn), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
        .err_sel(err_sel), .lat(lat), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .mem_rsp_err(mem_rsp_err));
    always #10 clk = ~clk;
    task automatic tally_and_finish;
    begin
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // Counts exception pulses and cuts a hang short.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (exc_valid_q === 1'b1)
            exc_n <= exc_n + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic wait_ready;
        int n;
    begin
        n = 0;
        @(negedge clk);
        while (instr_ready_q !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
    end
    endtask
    task automatic issue(input logic [15:0] w);
    begin
        wait_ready();
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        // Ready was seen high, so the word is taken at this edge; holding valid longer re-issues it.
        @(posedge clk);
        instr_valid <= 1'b0;
    end
    endtask
    task automatic gpr_is(input logic [4:0] idx, input logic [31:0] exp);
    begin
        wait_ready();
        @(posedge clk);
        gpr_rd_idx <= idx;
        @(posedge clk);
        @(negedge clk);
        chk(gpr_rd_data_q, exp);
    end
    endtask
    task automatic prod_is(input logic up, input logic [31:0] exp);
        int n;
    begin
        n = 0;
        @(posedge clk);
        prod_rd_req <= 1'b1;
        prod_rd_upper <= up;
        @(posedge clk);
        prod_rd_req <= 1'b0;
        @(negedge clk);
        while (prod_rd_valid_q !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk(prod_rd_data_q, exp);
    end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    end
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    begin
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        chk(bus_rdata_q, exp);
    end
    endtask
    task automatic t_unwind;
    begin
        issue(16'h6470);
        gpr_is(5'h1F, 32'hF000_007D);
        gpr_is(5'h11, 32'hF000_0079);
        gpr_is(5'h10, 32'hF000_0075);
        gpr_is(5'h1D, 32'h0000_0080);
        lat <= 4'h0;
        issue(16'h640F);
        gpr_is(5'h1D, 32'h0000_00F8);
    end
    endtask
    task automatic t_copy_alu;
        logic signed [63:0] ps;
        logic [63:0]        pu;
    begin
        issue(16'h6540);
        gpr_is(5'h02, 32'hF000_0075);
        issue(16'h677F);
        gpr_is(5'h03, 32'hF000_007D);
        issue(16'h6551);
        gpr_is(5'h12, 32'hF000_0079);
        issue(16'h6500);
        gpr_is(5'h00, 32'h0);
        gpr_is(5'h10, 32'hF000_0075);
        ps = $signed(32'hF000_0075) * $signed(32'hF000_007D);
        pu = 64'hF000_0075 * 64'hF000_007D;
        issue(16'hEA78);
        prod_is(1'b1, ps[63:32]);
        prod_is(1'b0, ps[31:0]);
        issue(16'hEA79);
        prod_is(1'b0, pu[31:0]);
        prod_is(1'b1, pu[63:32]);
        chk(32'(exc_n), 32'h0);
        issue(16'hEC4B);
        gpr_is(5'h04, 32'h0 - 32'hF000_0075);
        issue(16'hED6F);
        gpr_is(5'h05, ~32'hF000_007D);
        issue(16'hECAD);
        gpr_is(5'h04, (32'h0 - 32'hF000_0075) | ~32'hF000_007D);
    end
    endtask
    task automatic t_faults;
    begin
        issue(16'h65B8);
        issue(16'h6441);
        repeat (3) @(negedge clk);
        chk(32'(exc_n), 32'h1);
        chk({29'h0, exc_code_q}, 32'h1);
        chk(exc_addr_q, 32'hF000_0079);
        gpr_is(5'h1D, 32'hF000_0075);
        issue(16'h6401);
        gpr_is(5'h1D, 32'hF000_007D);
        chk(32'(exc_n), 32'h1);
        issue(16'h65BE);
        gpr_is(5'h1D, 32'h0);
        for (int e = 1; e < 4; e++)
        begin
            err_sel <= 2'(e);
            issue(16'h6452);
            gpr_is(5'h1D, 32'h0);
            chk({29'h0, exc_code_q}, 32'(e + 1));
            chk(exc_addr_q, 32'h0000_000C);
        end
        err_sel <= 2'h0;
        issue(16'h6452);
        gpr_is(5'h1F, 32'hF000_000D);
        gpr_is(5'h11, 32'hF000_0009);
        gpr_is(5'h1D, 32'h0000_0010);
    end
    endtask
    task automatic t_irq;
    begin
        bus_read(8'h00, 32'hF);
        bus_write(8'h08, 32'h2);
        bus_read(8'h08, 32'h2);
        chk(32'(irq_q), 32'h1);
        bus_write(8'h08, 32'h0);
        bus_read(8'hFC, 32'h0);
        chk(32'(irq_q), 32'h0);
        bus_write(8'h08, 32'h2);
        bus_write(8'h00, 32'h0);
        bus_read(8'h00, 32'hF);
        bus_write(8'h04, 32'hF);
        bus_read(8'h00, 32'h0);
        chk(32'(irq_q), 32'h0);
    end
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        bus_read(8'h08, 32'h0);
        t_unwind();
        t_copy_alu();
        t_faults();
        t_irq();
        tally_and_finish();
    end
endmodule
